// ===== bench/usbxa_host_model.sv
`timescale 1ns/100ps
// host end of the cable: pulldowns on both lines, idle j only on request
module usbxa_host_model (
   // device line drive
   input wire logic dplus_out,
   input wire logic dplus_oe,
   input wire logic dminus_out,
   input wire logic dminus_oe,
   input wire logic dplus_pullup_en,
   input wire logic dminus_pullup_en,
   // host request and resolved lines
   input wire logic host_j,
   output logic dplus_in,
   output logic dminus_in
);
   // device drive wins; host pulldowns lose to a pull-up, or on D+ to a host j, which holds D- low
   assign dplus_in = dplus_oe ? dplus_out : (host_j | dplus_pullup_en);
   assign dminus_in = dminus_oe ? dminus_out : (!host_j & dminus_pullup_en);
endmodule // usbxa_host_model

// ===== bench/usbxa_top_properties.sv
`timescale 1ns/100ps
// port checks for transceiver control and the indirect window
module usbxa_top_properties
   import usbxa_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // lines
   input wire logic vbus_present,
   input wire logic dplus_out,
   input wire logic dplus_oe,
   input wire logic dminus_out,
   input wire logic dminus_oe,
   input wire logic dplus_pullup_en,
   input wire logic dminus_pullup_en,
   input wire logic phy_suspend,
   input wire logic full_speed
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   logic mapped;
   logic xc_wr;
   // decode helpers
   assign mapped = reg_addr inside {ADDR_INDIRECT_ADDRESS, ADDR_INDIRECT_DATA,
      ADDR_TRANSCEIVER_CONTROL};
   assign xc_wr = reg_wr && reg_addr == ADDR_TRANSCEIVER_CONTROL;
   // busy start followed by three quiet polls of the address register
   sequence s_start; reg_wr && reg_addr == ADDR_INDIRECT_ADDRESS && reg_wdata[IA_BUSY]; endsequence
   sequence s_poll; (!reg_wr && reg_addr == ADDR_INDIRECT_ADDRESS)[*3]; endsequence
   property p_busy; s_start ##1 s_poll |-> reg_rdata[IA_BUSY] ##1 !reg_rdata[IA_BUSY]; endproperty
   a_busy: assert property (p_busy) else $error("busy timing");
   property p_unmapped; !mapped |=> reg_rdata == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_pu_hi; dplus_pullup_en |-> full_speed && !dminus_pullup_en; endproperty
   a_pu_hi: assert property (p_pu_hi) else $error("pull-up on wrong line");
   property p_pu_lo; dminus_pullup_en |-> !full_speed; endproperty
   a_pu_lo: assert property (p_pu_lo) else $error("pull-up on wrong line");
   property p_vbus; !vbus_present [*4] |-> !dplus_pullup_en && !dminus_pullup_en; endproperty
   a_vbus: assert property (p_vbus) else $error("pull-up without vbus");
   property p_se0; dplus_oe |-> !(dplus_out && dminus_out); endproperty
   a_se0: assert property (p_se0) else $error("both lines forced high");
   property p_drive; xc_wr && reg_wdata[6] && reg_wdata[4:3] != 2'b00 |-> ##2 dplus_oe && dminus_oe;
   endproperty
   a_drive: assert property (p_drive) else $error("test mode not driving");
   property p_susp; xc_wr |-> ##2 phy_suspend == !$past(reg_wdata[XC_PHY_ENABLE], 2); endproperty
   a_susp: assert property (p_susp) else $error("suspend wrong");
endmodule // usbxa_top_properties

bind usbxa_top usbxa_top_properties i_usbxa_top_properties (.clk_sys(clk_sys), .srst(srst),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .vbus_present(vbus_present), .dplus_out(dplus_out), .dplus_oe(dplus_oe),
   .dminus_out(dminus_out), .dminus_oe(dminus_oe), .dplus_pullup_en(dplus_pullup_en),
   .dminus_pullup_en(dminus_pullup_en), .phy_suspend(phy_suspend), .full_speed(full_speed));

// ===== bench/usbxa_top_tb.sv
`timescale 1ns/100ps
// register-level test of transceiver control and the indirect window
module usbxa_top_tb;
   import usbxa_pkg::*;
   logic clk_sys, srst, reg_wr, reg_rd, vbus_present, host_j, want_dplus, want_dminus;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
   logic dplus_in, dminus_in, dplus_out, dplus_oe, dminus_out, dminus_oe;
   logic dplus_pullup_en, dminus_pullup_en, phy_suspend, full_speed;
   logic [7:0] al [4] = '{8'h96, 8'h97, 8'hd7, 8'h55};
   int n_mismatch = 0;
   int compares = 0;
   int cyc = 0;
   usbxa_top i_usbxa_top (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .dplus_in(dplus_in), .dminus_in(dminus_in), .vbus_present(vbus_present),
      .dplus_out(dplus_out), .dplus_oe(dplus_oe), .dminus_out(dminus_out),
      .dminus_oe(dminus_oe), .dplus_pullup_en(dplus_pullup_en),
      .dminus_pullup_en(dminus_pullup_en), .phy_suspend(phy_suspend), .full_speed(full_speed));
   usbxa_host_model i_usbxa_host_model (.dplus_out(dplus_out), .dplus_oe(dplus_oe),
      .dminus_out(dminus_out), .dminus_oe(dminus_oe), .dplus_pullup_en(dplus_pullup_en),
      .dminus_pullup_en(dminus_pullup_en), .host_j(host_j), .dplus_in(dplus_in),
      .dminus_in(dminus_in));
   // clock
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch = n_mismatch + 1;
         wrap_up();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // one-cycle strobes, launched just after an edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      idle(1);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      idle(1);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      idle(1);
      reg_addr = a;
      reg_rd = 1'b1;
      idle(1);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
   task automatic poll();
      for (int i = 0; i < 20; i++) begin
         rd(ADDR_INDIRECT_ADDRESS, v);
         if (v[IA_BUSY] === 1'b0) break;
      end
      chk({7'h0, v[IA_BUSY]}, 8'h00);
   endtask
   task automatic sel(input int e);
      wr(ADDR_INDIRECT_ADDRESS, {2'b00, INT_ADDR_INDEX});
      wr(ADDR_INDIRECT_DATA, 8'(e));
   endtask
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      srst = 1'b1;
      {reg_wr, reg_rd, reg_addr, reg_wdata, host_j} = '0;
      vbus_present = 1'b1;
      idle(10);
      srst = 1'b0;
      // reset values, plus one unmapped address
      foreach (al[i]) begin
         rd(al[i], v);
         chk(v, 8'h00);
      end
      chk({7'h0, phy_suspend}, 8'h01);
      $display("test reset done");
      // pull-up side follows speed; vbus or enable loss detaches
      for (int s = 0; s < 2; s++) begin
         wr(ADDR_TRANSCEIVER_CONTROL, {2'b10, s[0], 5'h00});
         idle(5);
         chk({6'h0, dplus_pullup_en, dminus_pullup_en}, {6'h0, s[0], !s[0]});
         chk({7'h0, full_speed}, {7'h0, s[0]});
      end
      vbus_present = 1'b0;
      idle(5);
      chk({6'h0, dplus_pullup_en, dminus_pullup_en}, 8'h00);
      vbus_present = 1'b1;
      wr(ADDR_TRANSCEIVER_CONTROL, 8'h20);
      idle(5);
      chk({6'h0, dplus_pullup_en, dminus_pullup_en}, 8'h00);
      $display("test pull-up done");
      // every line test mode; mode 0 sees the host j; clock taken as running
      for (int m = 0; m < 4; m++) begin
         host_j = (m == 0);
         want_dplus = (m < 2);
         want_dminus = (m == 2);
         wr(ADDR_TRANSCEIVER_CONTROL, {3'b010, m[1:0], 3'b000});
         idle(8);
         // drive levels only matter while enabled, so mask them with the enables
         v = {4'h0, dplus_out & dplus_oe, dplus_oe, dminus_out & dminus_oe, dminus_oe};
         chk(v, {4'h0, want_dplus & (m != 0), m != 0, want_dminus, m != 0});
         chk({7'h0, phy_suspend}, 8'h00);
         rd(ADDR_TRANSCEIVER_CONTROL, v);
         chk(v, {3'b010, m[1:0], want_dplus & !want_dminus, want_dplus, want_dminus});
      end
      wr(ADDR_TRANSCEIVER_CONTROL, 8'h00);
      idle(3);
      chk({7'h0, phy_suspend}, 8'h01);
      $display("test line modes done");
      // banked writes through the window, then busy reads back per endpoint
      for (int e = 0; e < NUM_ENDPOINTS; e++) begin
         sel(e);
         wr(ADDR_INDIRECT_ADDRESS, 8'h11);
         wr(ADDR_INDIRECT_DATA, 8'ha0 + 8'(e));
      end
      for (int e = 0; e < NUM_ENDPOINTS; e++) begin
         sel(e);
         wr(ADDR_INDIRECT_ADDRESS, 8'h91);
         poll();
         rd(ADDR_INDIRECT_DATA, v);
         chk(v, 8'ha0 + 8'(e));
      end
      $display("test window done");
      // auto-read relaunches on a data read; writing busy zero is inert
      wr(ADDR_INDIRECT_ADDRESS, 8'hd1);
      poll();
      rd(ADDR_INDIRECT_DATA, v);
      chk(v, 8'ha3);
      rd(ADDR_INDIRECT_ADDRESS, v);
      chk(v, 8'hd1);
      poll();
      wr(ADDR_INDIRECT_ADDRESS, 8'h11);
      rd(ADDR_INDIRECT_ADDRESS, v);
      chk(v, 8'h11);
      $display("test auto-read done");
      wrap_up();
   end
endmodule // usbxa_top_tb

// ===== include/usbxa_pkg.sv
package usbxa_pkg;
   // special register addresses on the processor register port
   localparam logic [7:0] ADDR_INDIRECT_ADDRESS = 8'h96;
   localparam logic [7:0] ADDR_INDIRECT_DATA = 8'h97;
   localparam logic [7:0] ADDR_TRANSCEIVER_CONTROL = 8'hd7;
   // reset values
   localparam logic [7:0] RST_INDIRECT_ADDRESS = 8'h00;
   localparam logic [7:0] RST_INDIRECT_DATA = 8'h00;
   localparam logic [7:0] RST_TRANSCEIVER_CONTROL = 8'h00;
   // transceiver control fields
   localparam int XC_PULLUP_ENABLE = 7;
   localparam int XC_PHY_ENABLE = 6;
   localparam int XC_SPEED = 5;
   localparam int XC_TEST_HI = 4;
   localparam int XC_TEST_LO = 3;
   localparam int XC_DIFF_RX = 2;
   localparam int XC_DPLUS = 1;
   localparam int XC_DMINUS = 0;
   // indirect address fields
   localparam int IA_BUSY = 7;
   localparam int IA_AUTO_READ = 6;
   localparam int IA_TARGET_WIDTH = 6;
   // internal register space
   localparam logic [5:0] INT_ADDR_INDEX = 6'h0e;
   localparam int INT_DEPTH = 64;
   localparam int NUM_ENDPOINTS = 4;
   localparam int NUM_PIPES = 8;
   // internal read latency in cycles (memory register stage)
   localparam int READ_LATENCY = 1;
   // line test modes
   typedef enum logic [1:0] {
      USBXA_TEST_NORMAL = 2'b00,
      USBXA_TEST_J = 2'b01,
      USBXA_TEST_K = 2'b10,
      USBXA_TEST_SE0 = 2'b11
   } usbxa_test_t;
endpackage

// ===== verilog/usbxa_regmem.sv
`timescale 1ns/100ps
// internal register store: indexed regions banked per endpoint, registered read data
module usbxa_regmem
   import usbxa_pkg::*;
#(
   parameter int ADDR_WIDTH = 6,
   parameter int BANKS = 4
) (
   // clock
   input wire logic clk_sys,
   // access
   input wire logic wr_en,
   input wire logic [ADDR_WIDTH+1:0] addr,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data
);
   logic [7:0] mem [0:(BANKS << ADDR_WIDTH)-1];

   // storage has no reset: software sets registers before use
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[addr] <= wr_data;
      end
      rd_data <= mem[addr];
   end
endmodule // usbxa_regmem

// ===== verilog/usbxa_top.sv
`timescale 1ns/100ps
// How it works
// - function only, full and low speed behaviour; no host logic exists here
// - eight pipes: endpoint 0 bidirectional, endpoints 1-3 each IN and OUT
// - speed bit one: full speed, pull-up on D+; zero: low speed, D-
// - pull-up connects only with enable bit set and VBUS present
// - internal registers reached only via address and data registers
module usbxa_top
   import usbxa_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // processor register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // bus pins and vbus sense (asynchronous)
   input wire logic dplus_in,
   input wire logic dminus_in,
   input wire logic vbus_present,
   // line drive
   output logic dplus_out,
   output logic dplus_oe,
   output logic dminus_out,
   output logic dminus_oe,
   output logic dplus_pullup_en,
   output logic dminus_pullup_en,
   output logic phy_suspend,
   output logic full_speed
);
   // pin synchronisers
   logic [2:0] pin_meta_reg;
   logic [2:0] pin_sync_reg;
   always_ff @(posedge clk_sys) begin
      pin_meta_reg <= {vbus_present, dplus_in, dminus_in};
      pin_sync_reg <= pin_meta_reg;
   end
   logic vbus_s, dplus_level, dminus_level;
   assign vbus_s = pin_sync_reg[2];
   assign dplus_level = pin_sync_reg[1];
   assign dminus_level = pin_sync_reg[0];

   // writable state
   logic pullup_enable_reg, pullup_enable_next;
   logic phy_enable_reg, phy_enable_next;
   logic speed_reg, speed_next;
   logic [1:0] phy_test_select_reg, phy_test_select_next;
   logic busy_reg, busy_next;
   logic auto_read_enable_reg, auto_read_enable_next;
   logic [5:0] indirect_target_address_reg, indirect_target_address_next;
   logic [7:0] indirect_data_reg, indirect_data_next;
   logic [1:0] ep_index_reg, ep_index_next;
   logic [READ_LATENCY:0] rd_pipe_reg, rd_pipe_next;

   // internal store access
   logic mem_wr;
   logic [7:0] mem_rdata;
   logic [7:0] mem_addr;
   logic indexed;
   logic differential_rx_state;

   // 0x10-0x17 are endpoint indexed, banked by the index register
   assign indexed = (indirect_target_address_reg[5:3] == 3'b010);
   assign mem_addr = {indexed ? ep_index_reg : 2'b00, indirect_target_address_reg};
   assign mem_wr = reg_wr && (reg_addr == ADDR_INDIRECT_DATA) && !busy_reg;
   assign differential_rx_state = phy_enable_reg & dplus_level & ~dminus_level;

   usbxa_regmem #(
      .ADDR_WIDTH(IA_TARGET_WIDTH),
      .BANKS(NUM_ENDPOINTS)
   ) u_regmem (
      .clk_sys(clk_sys),
      .wr_en(mem_wr),
      .addr(mem_addr),
      .wr_data(reg_wdata),
      .rd_data(mem_rdata)
   );

   // next-state for control and indirect window
   always_comb begin
      pullup_enable_next = pullup_enable_reg;
      phy_enable_next = phy_enable_reg;
      speed_next = speed_reg;
      phy_test_select_next = phy_test_select_reg;
      busy_next = busy_reg;
      auto_read_enable_next = auto_read_enable_reg;
      indirect_target_address_next = indirect_target_address_reg;
      indirect_data_next = indirect_data_reg;
      ep_index_next = ep_index_reg;
      rd_pipe_next = {rd_pipe_reg[READ_LATENCY-1:0], 1'b0};
      if (reg_wr && reg_addr == ADDR_TRANSCEIVER_CONTROL) begin
         pullup_enable_next = reg_wdata[XC_PULLUP_ENABLE];
         phy_enable_next = reg_wdata[XC_PHY_ENABLE];
         speed_next = reg_wdata[XC_SPEED];
         phy_test_select_next = reg_wdata[XC_TEST_HI:XC_TEST_LO];
      end
      if (reg_wr && reg_addr == ADDR_INDIRECT_ADDRESS) begin
         auto_read_enable_next = reg_wdata[IA_AUTO_READ];
         indirect_target_address_next = reg_wdata[IA_TARGET_WIDTH-1:0];
         // writing zero to busy leaves it alone
         if (reg_wdata[IA_BUSY] && !busy_reg) begin
            busy_next = 1'b1;
            rd_pipe_next[0] = 1'b1;
         end
      end
      // direct writes take effect immediately; mirror index for banking
      if (mem_wr) begin
         indirect_data_next = reg_wdata;
         if (indirect_target_address_reg == INT_ADDR_INDEX) begin
            ep_index_next = reg_wdata[1:0];
         end
      end
      // auto-read chains the next read off a data read
      if (reg_rd && reg_addr == ADDR_INDIRECT_DATA && auto_read_enable_reg && !busy_reg) begin
         busy_next = 1'b1;
         rd_pipe_next[0] = 1'b1;
      end
      // memory data valid: latch and drop busy
      if (rd_pipe_reg[READ_LATENCY]) begin
         indirect_data_next = mem_rdata;
         busy_next = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pullup_enable_reg <= RST_TRANSCEIVER_CONTROL[XC_PULLUP_ENABLE];
         phy_enable_reg <= RST_TRANSCEIVER_CONTROL[XC_PHY_ENABLE];
         speed_reg <= RST_TRANSCEIVER_CONTROL[XC_SPEED];
         phy_test_select_reg <= RST_TRANSCEIVER_CONTROL[XC_TEST_HI:XC_TEST_LO];
         busy_reg <= RST_INDIRECT_ADDRESS[IA_BUSY];
         auto_read_enable_reg <= RST_INDIRECT_ADDRESS[IA_AUTO_READ];
         indirect_target_address_reg <= RST_INDIRECT_ADDRESS[IA_TARGET_WIDTH-1:0];
         indirect_data_reg <= RST_INDIRECT_DATA;
         ep_index_reg <= 2'h0;
         rd_pipe_reg <= '0;
      end else begin
         pullup_enable_reg <= pullup_enable_next;
         phy_enable_reg <= phy_enable_next;
         speed_reg <= speed_next;
         phy_test_select_reg <= phy_test_select_next;
         busy_reg <= busy_next;
         auto_read_enable_reg <= auto_read_enable_next;
         indirect_target_address_reg <= indirect_target_address_next;
         indirect_data_reg <= indirect_data_next;
         ep_index_reg <= ep_index_next;
         rd_pipe_reg <= rd_pipe_next;
      end
   end

   // read mux and line outputs, all registered
   logic [7:0] rdata_next;
   logic dplus_drv_next, dplus_en_next, dminus_drv_next, dminus_en_next;
   always_comb begin
      unique case (reg_addr)
         ADDR_INDIRECT_ADDRESS: rdata_next = {busy_reg, auto_read_enable_reg,
            indirect_target_address_reg};
         ADDR_INDIRECT_DATA: rdata_next = indirect_data_reg;
         ADDR_TRANSCEIVER_CONTROL: rdata_next = {pullup_enable_reg, phy_enable_reg,
            speed_reg, phy_test_select_reg, differential_rx_state, dplus_level,
            dminus_level};
         default: rdata_next = 8'h00;
      endcase
      // forced line states only while the transceiver runs
      dplus_drv_next = 1'b0;
      dminus_drv_next = 1'b0;
      dplus_en_next = 1'b0;
      dminus_en_next = 1'b0;
      if (phy_enable_reg) begin
         unique case (usbxa_test_t'(phy_test_select_reg))
            USBXA_TEST_NORMAL: begin
               dplus_en_next = 1'b0;
            end
            USBXA_TEST_J: begin
               dplus_drv_next = 1'b1;
               dplus_en_next = 1'b1;
               dminus_en_next = 1'b1;
            end
            USBXA_TEST_K: begin
               dminus_drv_next = 1'b1;
               dplus_en_next = 1'b1;
               dminus_en_next = 1'b1;
            end
            USBXA_TEST_SE0: begin
               dplus_en_next = 1'b1;
               dminus_en_next = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         reg_rdata <= 8'h00;
         dplus_out <= 1'b0;
         dplus_oe <= 1'b0;
         dminus_out <= 1'b0;
         dminus_oe <= 1'b0;
         dplus_pullup_en <= 1'b0;
         dminus_pullup_en <= 1'b0;
         phy_suspend <= 1'b1;
         full_speed <= 1'b0;
      end else begin
         reg_rdata <= rdata_next;
         dplus_out <= dplus_drv_next;
         dplus_oe <= dplus_en_next;
         dminus_out <= dminus_drv_next;
         dminus_oe <= dminus_en_next;
         dplus_pullup_en <= pullup_enable_reg & vbus_s & speed_reg;
         dminus_pullup_en <= pullup_enable_reg & vbus_s & ~speed_reg;
         phy_suspend <= ~phy_enable_reg;
         full_speed <= speed_reg;
      end
   end
endmodule // usbxa_top
